// file: rtl/bsdr_pkg.sv
// Purpose: Shared constants and types of the boundary-scan data path.
// Assumes: One 8-bit instruction register and a 113-cell boundary chain.
// Notes: Opcodes not listed here are reserved and fall back to the bypass path.
package bsdr_pkg;

    localparam int IR_W = 8;
    localparam int BSR_W = 113;
    localparam int ID_W = 32;
    localparam int FIFO_DEPTH = 16;

    localparam logic [IR_W-1:0] OP_EXTEST = 8'h00;
    localparam logic [IR_W-1:0] OP_IDCODE = 8'h01;
    localparam logic [IR_W-1:0] OP_HIGHZ = 8'h03;
    localparam logic [IR_W-1:0] OP_SAMPLE = 8'h05;
    localparam logic [IR_W-1:0] OP_CLAMP = 8'h07;
    localparam logic [IR_W-1:0] OP_BYPASS = 8'hff;

    // Capture pattern of the instruction shifter; the low two bits are fixed at 01.
    localparam logic [IR_W-1:0] IR_CAPTURE = 8'h01;
    localparam logic [IR_W-1:0] IR_RESET = OP_IDCODE;
    localparam logic BYPASS_CAPTURE = 1'b0;

    typedef enum logic [15:0] {
        ST_RESET = 16'h0001,
        ST_IDLE = 16'h0002,
        ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008,
        ST_SHIFT_DR = 16'h0010,
        ST_EXIT1_DR = 16'h0020,
        ST_PAUSE_DR = 16'h0040,
        ST_EXIT2_DR = 16'h0080,
        ST_UPD_DR = 16'h0100,
        ST_SEL_IR = 16'h0200,
        ST_CAP_IR = 16'h0400,
        ST_SHIFT_IR = 16'h0800,
        ST_EXIT1_IR = 16'h1000,
        ST_PAUSE_IR = 16'h2000,
        ST_EXIT2_IR = 16'h4000,
        ST_UPD_IR = 16'h8000
    } bsdr_state_t;

endpackage

// file: rtl/bsdr_sync.sv
// Purpose: Two-stage synchroniser for a bundle of pin inputs.
// Assumes: Each bit is an independent level from outside the ref_clk domain.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module bsdr_sync #(
    parameter int W = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;

endmodule // bsdr_sync

// file: rtl/bsdr_fifo.sv
// Purpose: Synchronous FIFO with valid and ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes: Full and empty come from pointers carrying one extra wrap bit.
`timescale 1ns/1ps
module bsdr_fifo #(
    parameter int W = 113,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);

    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic push;
    logic pop;

    assign in_ready = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
    assign out_valid = (wr_q != rd_q);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_q[AW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_q + (AW+1)'(push);
            rd_q <= rd_q + (AW+1)'(pop);
        end
    end

endmodule // bsdr_fifo

// file: rtl/bsdr_top.sv
// Purpose: Test access port controller, instruction decode and scan data registers.
// Assumes: tck, tms and tdi are pins sampled by ref_clk, which runs well above tck.
// Notes: Ring snapshots arrive through a FIFO; capture takes the oldest waiting snapshot.
//
// Behaviour
// - Exactly one scan register sits between serial input and output, chosen by instruction.
// - Serial input is sampled on test-clock rise; serial output changes on its fall.
// - A shifted instruction becomes active only in the update-IR state.
// - Power-up and test-logic-reset both make IDCODE the active instruction.
// - Capture-IR loads the low two instruction shifter bits with binary 01.
// - Bypass register is one bit and is cleared in capture-DR whenever bypass is the selected register.
// - Capture-DR loads the ring values into the boundary chain; shift-DR shifts it.
// - Boundary chain has 113 cells; serial input at top, output from bit zero.
// - IDCODE capture-DR loads the fixed 32-bit identification value.
// - Instruction register is eight bits and shifts in the Shift-IR state.
// - EXTEST drives held vector on outputs from update-IR; inputs capture results.
// - IDCODE places the identification register in the serial path.
// - High-Z selects bypass and forces every output ball to high impedance.
// - CLAMP drives output balls from the values held in the boundary chain.
// - SAMPLE/PRELOAD capture-DR snapshots input and bidirectional balls into the chain.
// - BYPASS in shift-DR places the bypass bit in the serial path.
// - Five test-clock rises with mode-select high reset the test port.
// - Serial output driver is enabled only in Shift-IR and Shift-DR.
// - The all-ones instruction pattern decodes as BYPASS.
`timescale 1ns/1ps
module bsdr_top #(
    parameter int BSR_W = bsdr_pkg::BSR_W,
    parameter int FIFO_DEPTH = bsdr_pkg::FIFO_DEPTH,
    // Identification value is arbitrary; bit zero marks the register as present.
    parameter logic [bsdr_pkg::ID_W-1:0] ID_VALUE = 32'h1000_0001
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    input wire logic [BSR_W-1:0] ring_data,
    input wire logic ring_valid,
    output logic ring_ready,
    output logic [BSR_W-1:0] pin_test_data,
    output logic pin_test_drive,
    output logic pin_force_hiz,
    output logic [bsdr_pkg::IR_W-1:0] active_instruction
);

    localparam int IR_W = bsdr_pkg::IR_W;
    localparam int ID_W = bsdr_pkg::ID_W;

    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic tck_last_q;
    logic tck_rise;
    logic tck_fall;

    bsdr_pkg::bsdr_state_t state_q;
    bsdr_pkg::bsdr_state_t state_d;

    logic [IR_W-1:0] ir_shift_q;
    logic [IR_W-1:0] scan_instruction_q;
    logic scan_bypass_bit_q;
    logic [BSR_W-1:0] pin_boundary_chain_q;
    logic [BSR_W-1:0] boundary_hold_q;
    logic [ID_W-1:0] part_identification_q;
    logic [BSR_W-1:0] ring_last_q;
    logic tdo_q;
    logic tdo_oe_q;
    logic test_drive_q;
    logic force_hiz_q;

    logic [BSR_W-1:0] fifo_data;
    logic fifo_valid;
    logic fifo_pop;
    logic [BSR_W-1:0] ring_now;

    logic st_reset;
    logic st_cap_dr;
    logic st_shift_dr;
    logic st_upd_dr;
    logic st_cap_ir;
    logic st_shift_ir;
    logic st_upd_ir;
    logic op_extest;
    logic op_sample;
    logic op_idcode;
    logic op_clamp;
    logic op_highz;
    logic sel_boundary;
    logic sel_ident;
    logic sel_bypass;
    logic dr_serial_out;
    logic ir_capture_en;
    logic ir_shift_en;
    logic ir_load_en;
    logic ir_reset_en;
    logic byp_capture_en;
    logic byp_shift_en;
    logic bsr_capture_en;
    logic bsr_shift_en;
    logic bsr_update_en;
    logic id_capture_en;
    logic id_shift_en;
    logic [IR_W-1:0] ir_shifted;
    logic [BSR_W-1:0] chain_shifted;
    logic [ID_W-1:0] ident_shifted;
    logic tdo_d;
    logic tdo_oe_d;
    logic test_drive_d;
    logic force_hiz_d;

    // Pins are asynchronous to ref_clk; all three share one delay so tdi and tms
    // stay aligned with the tck edge that is found from them.
    bsdr_sync #(
        .W(3)
    ) u_sync (
        .clk(ref_clk),
        .rst_n(rst_n),
        .d({tck, tms, tdi}),
        .q({tck_s, tms_s, tdi_s})
    );

    // Ring snapshots wait here until a capture takes one; the producer stalls on
    // ring_ready once all slots are taken.
    bsdr_fifo #(
        .W(BSR_W),
        .DEPTH(FIFO_DEPTH)
    ) u_ring_fifo (
        .clk(ref_clk),
        .rst_n(rst_n),
        .in_data(ring_data),
        .in_valid(ring_valid),
        .in_ready(ring_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );

    // Edges are found two sync stages late; each tck level must be sampled by at least
    // one ref_clk edge or an edge is lost, so tck runs well below ref_clk.
    assign tck_rise = tck_s && !tck_last_q;
    assign tck_fall = !tck_s && tck_last_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tck_last_q <= 1'b0;
        end else begin
            tck_last_q <= tck_s;
        end
    end

    // Controller next state; five rises with tms high reach reset from anywhere.
    always_comb begin
        state_d = state_q;
        case (state_q)
            bsdr_pkg::ST_RESET: state_d = tms_s ? bsdr_pkg::ST_RESET : bsdr_pkg::ST_IDLE;
            bsdr_pkg::ST_IDLE: state_d = tms_s ? bsdr_pkg::ST_SEL_DR : bsdr_pkg::ST_IDLE;
            bsdr_pkg::ST_SEL_DR: state_d = tms_s ? bsdr_pkg::ST_SEL_IR : bsdr_pkg::ST_CAP_DR;
            bsdr_pkg::ST_CAP_DR: state_d = tms_s ? bsdr_pkg::ST_EXIT1_DR : bsdr_pkg::ST_SHIFT_DR;
            bsdr_pkg::ST_SHIFT_DR: state_d = tms_s ? bsdr_pkg::ST_EXIT1_DR : bsdr_pkg::ST_SHIFT_DR;
            bsdr_pkg::ST_EXIT1_DR: state_d = tms_s ? bsdr_pkg::ST_UPD_DR : bsdr_pkg::ST_PAUSE_DR;
            bsdr_pkg::ST_PAUSE_DR: state_d = tms_s ? bsdr_pkg::ST_EXIT2_DR : bsdr_pkg::ST_PAUSE_DR;
            bsdr_pkg::ST_EXIT2_DR: state_d = tms_s ? bsdr_pkg::ST_UPD_DR : bsdr_pkg::ST_SHIFT_DR;
            bsdr_pkg::ST_UPD_DR: state_d = tms_s ? bsdr_pkg::ST_SEL_DR : bsdr_pkg::ST_IDLE;
            bsdr_pkg::ST_SEL_IR: state_d = tms_s ? bsdr_pkg::ST_RESET : bsdr_pkg::ST_CAP_IR;
            bsdr_pkg::ST_CAP_IR: state_d = tms_s ? bsdr_pkg::ST_EXIT1_IR : bsdr_pkg::ST_SHIFT_IR;
            bsdr_pkg::ST_SHIFT_IR: state_d = tms_s ? bsdr_pkg::ST_EXIT1_IR : bsdr_pkg::ST_SHIFT_IR;
            bsdr_pkg::ST_EXIT1_IR: state_d = tms_s ? bsdr_pkg::ST_UPD_IR : bsdr_pkg::ST_PAUSE_IR;
            bsdr_pkg::ST_PAUSE_IR: state_d = tms_s ? bsdr_pkg::ST_EXIT2_IR : bsdr_pkg::ST_PAUSE_IR;
            bsdr_pkg::ST_EXIT2_IR: state_d = tms_s ? bsdr_pkg::ST_UPD_IR : bsdr_pkg::ST_SHIFT_IR;
            bsdr_pkg::ST_UPD_IR: state_d = tms_s ? bsdr_pkg::ST_SEL_DR : bsdr_pkg::ST_IDLE;
            default: state_d = bsdr_pkg::ST_RESET;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= bsdr_pkg::ST_RESET;
        end else if (tck_rise) begin
            state_q <= state_d;
        end
    end

    assign st_reset = (state_q == bsdr_pkg::ST_RESET);
    assign st_cap_dr = (state_q == bsdr_pkg::ST_CAP_DR);
    assign st_shift_dr = (state_q == bsdr_pkg::ST_SHIFT_DR);
    assign st_upd_dr = (state_q == bsdr_pkg::ST_UPD_DR);
    assign st_cap_ir = (state_q == bsdr_pkg::ST_CAP_IR);
    assign st_shift_ir = (state_q == bsdr_pkg::ST_SHIFT_IR);
    assign st_upd_ir = (state_q == bsdr_pkg::ST_UPD_IR);

    // Instruction decode; reserved codes and all-ones fall through to bypass.
    assign op_extest = (scan_instruction_q == bsdr_pkg::OP_EXTEST);
    assign op_sample = (scan_instruction_q == bsdr_pkg::OP_SAMPLE);
    assign op_idcode = (scan_instruction_q == bsdr_pkg::OP_IDCODE);
    assign op_clamp = (scan_instruction_q == bsdr_pkg::OP_CLAMP);
    assign op_highz = (scan_instruction_q == bsdr_pkg::OP_HIGHZ);
    assign sel_boundary = op_extest || op_sample;
    assign sel_ident = op_idcode;
    assign sel_bypass = !sel_boundary && !sel_ident;

    // Per-register strobes: a scan register moves only on a detected tck rise while
    // the controller sits in its state and, for a data register, the instruction selects it.
    assign ir_capture_en = tck_rise && st_cap_ir;
    assign ir_shift_en = tck_rise && st_shift_ir;
    assign ir_load_en = tck_rise && st_upd_ir;
    assign ir_reset_en = tck_rise && st_reset;
    assign byp_capture_en = tck_rise && st_cap_dr && sel_bypass;
    assign byp_shift_en = tck_rise && st_shift_dr && sel_bypass;
    assign bsr_capture_en = tck_rise && st_cap_dr && sel_boundary;
    assign bsr_shift_en = tck_rise && st_shift_dr && sel_boundary;
    assign bsr_update_en = tck_rise && st_upd_dr && sel_boundary;
    assign id_capture_en = tck_rise && st_cap_dr && sel_ident;
    assign id_shift_en = tck_rise && st_shift_dr && sel_ident;

    assign ir_shifted = {tdi_s, ir_shift_q[IR_W-1:1]};
    assign chain_shifted = {tdi_s, pin_boundary_chain_q[BSR_W-1:1]};
    assign ident_shifted = {tdi_s, part_identification_q[ID_W-1:1]};

    // Instruction shifter.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ir_shift_q <= bsdr_pkg::IR_CAPTURE;
        end else if (ir_capture_en) begin
            ir_shift_q <= bsdr_pkg::IR_CAPTURE;
        end else if (ir_shift_en) begin
            ir_shift_q <= ir_shifted;
        end
    end

    // Active instruction.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            scan_instruction_q <= bsdr_pkg::IR_RESET;
        end else if (ir_reset_en) begin
            scan_instruction_q <= bsdr_pkg::IR_RESET;
        end else if (ir_load_en) begin
            scan_instruction_q <= ir_shift_q;
        end
    end

    // Bypass bit.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            scan_bypass_bit_q <= bsdr_pkg::BYPASS_CAPTURE;
        end else if (byp_capture_en) begin
            scan_bypass_bit_q <= bsdr_pkg::BYPASS_CAPTURE;
        end else if (byp_shift_en) begin
            scan_bypass_bit_q <= tdi_s;
        end
    end

    // The oldest queued ring snapshot is the one captured; with nothing queued the
    // last snapshot taken stands in, so a slow producer never blocks a capture.
    assign fifo_pop = bsr_capture_en && fifo_valid;
    assign ring_now = fifo_valid ? fifo_data : ring_last_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ring_last_q <= '0;
        end else if (fifo_pop) begin
            ring_last_q <= fifo_data;
        end
    end

    // Boundary chain: top bit takes serial input, bit zero feeds serial output.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_boundary_chain_q <= '0;
        end else if (bsr_capture_en) begin
            pin_boundary_chain_q <= ring_now;
        end else if (bsr_shift_en) begin
            pin_boundary_chain_q <= chain_shifted;
        end
    end

    // Held vector for the output balls, loaded only at update-DR so that shifting
    // never disturbs what the balls drive.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            boundary_hold_q <= '0;
        end else if (bsr_update_en) begin
            boundary_hold_q <= pin_boundary_chain_q;
        end
    end

    // Identification register.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            part_identification_q <= ID_VALUE;
        end else if (id_capture_en) begin
            part_identification_q <= ID_VALUE;
        end else if (id_shift_en) begin
            part_identification_q <= ident_shifted;
        end
    end

    assign dr_serial_out = sel_boundary ? pin_boundary_chain_q[0] :
                           sel_ident ? part_identification_q[0] : scan_bypass_bit_q;

    // Shift-IR shows the instruction shifter; every other state shows the selected
    // data register, which is harmless while the driver is off.
    assign tdo_d = st_shift_ir ? ir_shift_q[0] : dr_serial_out;
    assign tdo_oe_d = st_shift_ir || st_shift_dr;
    assign test_drive_d = op_extest || op_clamp;
    assign force_hiz_d = op_highz;

    // Serial output and its enable move only on the falling test clock.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else if (tck_fall) begin
            tdo_q <= tdo_d;
            tdo_oe_q <= tdo_oe_d;
        end
    end

    // Output ball control follows the active instruction, so EXTEST drives from
    // the update-IR that made it active.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            test_drive_q <= 1'b0;
            force_hiz_q <= 1'b0;
        end else begin
            test_drive_q <= test_drive_d;
            force_hiz_q <= force_hiz_d;
        end
    end

    assign tdo = tdo_q;
    assign tdo_oe = tdo_oe_q;
    assign pin_test_data = boundary_hold_q;
    assign pin_test_drive = test_drive_q;
    assign pin_force_hiz = force_hiz_q;
    assign active_instruction = scan_instruction_q;

endmodule // bsdr_top

// file: sim/bsdr_sva.sv
// Purpose: Port-level timing checks of the boundary-scan block.
// Assumes: tck is synchronised in two stages and its edges are detected one edge later.
// Notes: Reactions land on the third ref_clk edge after a tck pin edge, seen on the fourth.
`timescale 1ns/1ps
module bsdr_sva_chk #(
    parameter int BSR_W = 113
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic ring_ready,
    input wire logic [BSR_W-1:0] pin_test_data,
    input wire logic pin_test_drive,
    input wire logic pin_force_hiz,
    input wire logic [bsdr_pkg::IR_W-1:0] active_instruction
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    tdo_fall_a: assert property ($changed(tdo) |-> $past(tck, 4) && !$past(tck, 3))
        else $error("tdo moved away from a tck fall");
    oe_fall_a: assert property ($changed(tdo_oe) |-> $past(tck, 4) && !$past(tck, 3))
        else $error("tdo_oe moved away from a tck fall");
    id_reset_a: assert property ($rose(rst_n) |-> active_instruction == bsdr_pkg::OP_IDCODE)
        else $error("instruction after reset is not IDCODE");
    instr_rise_a: assert property ($changed(active_instruction) |->
        !$past(tck, 4) && $past(tck, 3))
        else $error("instruction changed away from a tck rise");
    hiz_follow_a: assert property (pin_force_hiz ==
        ($past(active_instruction) == bsdr_pkg::OP_HIGHZ))
        else $error("pin_force_hiz does not follow the instruction");
    drive_follow_a: assert property (pin_test_drive ==
        ($past(active_instruction) == bsdr_pkg::OP_EXTEST ||
         $past(active_instruction) == bsdr_pkg::OP_CLAMP))
        else $error("pin_test_drive does not follow the instruction");
    held_vec_a: assert property ($changed(pin_test_data) |->
        !$past(tck, 4) && $past(tck, 3) &&
        ($past(active_instruction) == bsdr_pkg::OP_EXTEST ||
         $past(active_instruction) == bsdr_pkg::OP_SAMPLE))
        else $error("held vector changed outside an update");
    ring_pop_a: assert property ($rose(ring_ready) |->
        $past(tck, 1) && $past(tck, 2) &&
        (active_instruction == bsdr_pkg::OP_EXTEST ||
         active_instruction == bsdr_pkg::OP_SAMPLE))
        else $error("snapshot taken outside a capture");
endmodule // bsdr_sva_chk

bind bsdr_top bsdr_sva_chk #(.BSR_W(BSR_W)) chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .tck(tck),
    .tdo(tdo), .tdo_oe(tdo_oe), .ring_ready(ring_ready), .pin_test_data(pin_test_data),
    .pin_test_drive(pin_test_drive), .pin_force_hiz(pin_force_hiz),
    .active_instruction(active_instruction));

// file: sim/bsdr_tester.sv
// Purpose: Board tester that walks the test port and scans registers.
// Assumes: Each tck half period lasts four ref_clk cycles, 400 ns a period.
// Notes: tck stands low between scans and tdi rests at its pull-up level.
`timescale 1ns/1ps
module bsdr_tester (
    input wire logic ref_clk,
    input wire logic tdo,
    input wire logic tdo_oe,
    output logic tck,
    output logic tms,
    output logic tdi
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // Result is sampled just before the rise, one ref_clk cycle after the fall moved it.
    task automatic step(input logic m, input logic d, output logic o);
        @(posedge ref_clk);
        tms <= m;
        tdi <= d;
        repeat (3) @(posedge ref_clk);
        // An undriven tdo has no pull; the model reads the inverse so a missing enable shows.
        o = tdo_oe ? tdo : !tdo;
        tck <= 1'h1;
        repeat (4) @(posedge ref_clk);
        tck <= 1'h0;
    endtask

    task automatic walk(input logic [7:0] m, input int n);
        logic o;
        for (int i = 0; i < n; i++) begin
            step(m[i], 1'h1, o);
        end
    endtask

    task automatic reset_tap();
        walk(8'h1f, 6);
    endtask

    task automatic scan_ir(input logic [7:0] op, output logic [7:0] cap);
        walk(8'h03, 4);
        for (int i = 0; i < 8; i++) begin
            step(i == 7, op[i], cap[i]);
        end
        walk(8'h01, 2);
    endtask

    task automatic scan_dr(input int n, input logic [127:0] din, output logic [127:0] dout);
        dout = '0;
        walk(8'h01, 3);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], dout[i]);
        end
        walk(8'h01, 2);
        tdi <= 1'h1;
    endtask
endmodule // bsdr_tester

// file: sim/tb_boundary_scan_data_registers.sv
// Purpose: Self-checking bench of the boundary-scan block.
// Assumes: Instructions follow the package opcodes; reserved codes are never sent.
// Notes: The FIFO is filled past full and drained by captures under EXTEST.
`timescale 1ns/1ps
module tb_boundary_scan_data_registers;
    localparam int BW = bsdr_pkg::BSR_W;
    // Identification value is arbitrary; only bit zero carries meaning.
    localparam logic [31:0] ID_V = 32'h2468_ace1;
    localparam logic [BW-1:0] W = {1'h0, {7{16'hc3a5}}};
    localparam logic [BW-1:0] P = {1'h1, {7{16'h5a96}}};
    logic ref_clk, rst_n, tck, tms, tdi, tdo, tdo_oe, ring_valid, ring_ready, drive, hiz;
    logic [BW-1:0] ring_data;
    logic [BW-1:0] pin_test_data;
    logic [7:0] ai;
    logic [7:0] cap;
    logic [127:0] dout;
    logic [7:0] ops [3] = '{bsdr_pkg::OP_HIGHZ, bsdr_pkg::OP_CLAMP, bsdr_pkg::OP_BYPASS};
    logic [1:0] pins [3] = '{2'h2, 2'h1, 2'h0};
    int errors;
    int comparisons;

    bsdr_top #(.BSR_W(BW), .FIFO_DEPTH(16), .ID_VALUE(ID_V)) dut_u (.ref_clk(ref_clk),
        .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
        .ring_data(ring_data), .ring_valid(ring_valid), .ring_ready(ring_ready),
        .pin_test_data(pin_test_data), .pin_test_drive(drive), .pin_force_hiz(hiz),
        .active_instruction(ai));
    bsdr_tester tst_u (.ref_clk(ref_clk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms),
        .tdi(tdi));

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'h0;
        forever #25 ref_clk = ~ref_clk;
    end

    // The whole run takes a few thousand cycles; this leaves a wide margin.
    initial begin
        #2000000;
        errors++;
        report_and_stop();
    end

    initial begin
        errors = 0;
        comparisons = 0;
        rst_n = 1'h0;
        ring_data = '0;
        ring_valid = 1'h0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'h1;
        @(negedge ref_clk);
        check(ai, bsdr_pkg::OP_IDCODE);
        check(tdo_oe, 1'h0);
        tst_u.reset_tap();
        tst_u.scan_dr(32, '0, dout);
        check(dout[31:0], ID_V);
        check(tdo_oe, 1'h0);
        for (int i = 0; i < 3; i++) begin
            tst_u.scan_ir(ops[i], cap);
            check(cap, bsdr_pkg::IR_CAPTURE);
            @(negedge ref_clk);
            check(ai, ops[i]);
            check({hiz, drive}, pins[i]);
            tst_u.scan_dr(4, 128'hb, dout);
            check(dout[3:0], 4'h6);
        end
        tst_u.scan_ir(bsdr_pkg::OP_SAMPLE, cap);
        @(posedge ref_clk);
        ring_data <= W;
        ring_valid <= 1'h1;
        @(posedge ref_clk);
        ring_valid <= 1'h0;
        tst_u.scan_dr(BW, 128'(P), dout);
        check(dout[BW-1:0], W);
        check(drive, 1'h0);
        tst_u.scan_ir(bsdr_pkg::OP_EXTEST, cap);
        @(negedge ref_clk);
        check(pin_test_data, P);
        check(drive, 1'h1);
        for (int k = 0; k < 16; k++) begin
            @(posedge ref_clk);
            ring_valid <= 1'h1;
            ring_data <= BW'(8'h40 + k);
        end
        @(posedge ref_clk);
        ring_data <= BW'(8'hee);
        repeat (3) @(posedge ref_clk);
        ring_valid <= 1'h0;
        @(negedge ref_clk);
        check(ring_ready, 1'h0);
        // The seventeenth capture finds the FIFO empty and repeats the last word.
        for (int k = 0; k < 17; k++) begin
            tst_u.scan_dr(8, '0, dout);
            check(dout[7:0], 8'(8'h40 + (k < 16 ? k : 15)));
        end
        check(ring_ready, 1'h1);
        tst_u.reset_tap();
        @(negedge ref_clk);
        check(ai, bsdr_pkg::OP_IDCODE);
        report_and_stop();
    end
endmodule // tb_boundary_scan_data_registers
